// ==== core/power_wakeup_reset_control.sv ====
`timescale 1ns/1ps
// Summary of operation
// - writing 5555h to standby entry from run stops cpu and system clocks
// - standby holds sram and io states until wakeup
// - wake on key change, rtc event or enabled irq1..irq7
// - on wakeup clocks restart, cpu resumes, no reset
// - armed key wakeup fires when pins 15:8 differ from latched value
// - software enables or disables the rtc independently
// - rtc gives a 0.5 s event that counts time and wakes cpu
// - oscillator drive strength selectable strong or weak
// - halt gates only the cpu clock
// - detection level selectable 2.6, 2.8, 3.0 or 3.2 V
// - bit 12 of voltage-detect control reads one when supply low
// - reset when supply below 2.4 V for 4 consecutive cycles
// - low-voltage reset always on, returns all to initial state except port latch and soft flag
// - watchdog overflow resets only when mask option enabled
// - 5555h to soft reset resets like pin and sets flag
// - stack access outside top..bottom range resets system
// - external reset pin is active low
// - fixed mask option decides whether watchdog may reset
module power_wakeup_reset_control
#(
    parameter int WDOG_CYCLES = power_wakeup_pkg::WDOG_CYCLES,
    parameter int RTC_EDGES = power_wakeup_pkg::RTC_EDGES,
    parameter int ADDR_W = 16
)
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic ext_reset_n,
    // software register writes
    input wire logic standby_entry_write,
    input wire logic soft_reset_write,
    input wire logic voltage_detect_write,
    input wire logic system_voltage_write,
    input wire logic [15:0] write_data,
    input wire logic halt_request,
    // key port
    input wire logic [15:0] port_a_pins,
    input wire logic port_a_read,
    input wire logic key_wake_enable,
    output logic [15:0] port_a_data_reg,
    // interrupts
    input wire logic [7:1] irq_request,
    input wire logic [7:1] irq_enable,
    // rtc oscillator
    input wire logic rtc_osc,
    output logic osc_strong_mode,
    output logic rtc_event,
    output logic [15:0] rtc_tick_count,
    // voltage comparators
    input wire logic lvd_below,
    input wire logic supply_below_2v4,
    output logic [1:0] lvd_level,
    output logic [15:0] voltage_detect_ctrl_reg,
    output logic [15:0] system_voltage_ctrl_reg,
    // watchdog
    input wire logic watchdog_mask_option,
    input wire logic watchdog_clear,
    // stack checker
    input wire logic stack_access,
    input wire logic [ADDR_W-1:0] stack_addr,
    input wire logic [ADDR_W-1:0] stack_top,
    input wire logic [ADDR_W-1:0] stack_bottom,
    // power control outputs
    output logic cpu_clock_enable,
    output logic system_clock_enable,
    output logic retention_hold,
    output logic wakeup_pulse,
    output logic system_reset
);

    localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);
    localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_CYCLES - 1);
    localparam logic [14:0] RTC_LAST = 15'(RTC_EDGES - 1);

    power_wakeup_pkg::power_state_t state_reg;
    power_wakeup_pkg::power_state_t state_next;
    logic [1:0] reset_pipe_reg;
    logic internal_reset;
    logic [7:0] key_latch_reg;
    logic key_change;
    logic irq_wake;
    logic wake;
    logic [14:0] rtc_count_reg;
    logic rtc_osc_prev_reg;
    logic rtc_enable_reg;
    logic [2:0] lvr_count_reg;
    logic lvr_trip;
    logic [WDOG_W-1:0] wdog_count_reg;
    logic wdog_overflow;
    logic wdog_option_reg;
    logic option_taken_reg;
    logic soft_trip;
    logic stack_trip;
    logic pin_trip;
    logic soft_flag_reg;
    logic lvd_low_reg;

    ////////////////////////////////////////////////////////////////////////
    // reset merge

    assign pin_trip = !ext_reset_n;
    assign soft_trip = soft_reset_write &&
        (write_data == power_wakeup_pkg::MAGIC_VALUE);
    assign stack_trip = stack_access &&
        ((stack_addr > stack_top) || (stack_addr < stack_bottom));

    // assertion is immediate on reset, release waits two clean edges
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            reset_pipe_reg <= 2'h3;
        else if (pin_trip || lvr_trip || wdog_overflow || soft_trip ||
                 stack_trip)
            reset_pipe_reg <= 2'h3;
        else
            reset_pipe_reg <= {reset_pipe_reg[0], 1'b0};
    end

    assign internal_reset = reset_pipe_reg[1];
    assign system_reset = reset || internal_reset;

    ////////////////////////////////////////////////////////////////////////
    // low-voltage reset, always active

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            lvr_count_reg <= 3'h0;
        else if (!supply_below_2v4)
            lvr_count_reg <= 3'h0;
        else if (lvr_count_reg != power_wakeup_pkg::LVR_CYCLES)
            lvr_count_reg <= lvr_count_reg + 3'h1;
    end

    assign lvr_trip =
        (lvr_count_reg == power_wakeup_pkg::LVR_CYCLES);

    a_lvr_after_four: assert property (@(posedge clock) disable iff (reset)
        supply_below_2v4 [*4] |-> ##2 system_reset)
        else $error("low voltage for four cycles gave no reset");

    a_lvr_not_early: assert property (@(posedge clock) disable iff (reset)
        !supply_below_2v4 ##1 supply_below_2v4 [*3] |-> !lvr_trip)
        else $error("low-voltage reset tripped before four cycles");

    ////////////////////////////////////////////////////////////////////////
    // watchdog option strap and counter

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            option_taken_reg <= 1'b0;
            wdog_option_reg <= 1'b0;
        end
        else if (!option_taken_reg)
        begin
            option_taken_reg <= 1'b1;
            wdog_option_reg <= watchdog_mask_option;
        end
    end

    // counter pauses while the system clock is stopped in standby
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            wdog_count_reg <= '0;
        else if (internal_reset || watchdog_clear)
            wdog_count_reg <= '0;
        else if (state_reg != power_wakeup_pkg::ST_STANDBY)
        begin
            if (wdog_count_reg == WDOG_LAST)
                wdog_count_reg <= '0;
            else
                wdog_count_reg <= wdog_count_reg + 1'b1;
        end
    end

    assign wdog_overflow = option_taken_reg && wdog_option_reg &&
        !watchdog_clear && !internal_reset &&
        (state_reg != power_wakeup_pkg::ST_STANDBY) &&
        (wdog_count_reg == WDOG_LAST);

    a_wdog_masked: assert property (@(posedge clock) disable iff (reset)
        wdog_overflow |-> wdog_option_reg)
        else $error("watchdog reset while option disabled");

    a_wdog_resets: assert property (@(posedge clock) disable iff (reset)
        wdog_overflow |=> system_reset [*2])
        else $error("watchdog overflow did not reset");

    ////////////////////////////////////////////////////////////////////////
    // software reset flag and configuration

    // a new soft reset wins over a software clear in the same cycle
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            soft_flag_reg <= 1'b0;
        else if (soft_trip)
            soft_flag_reg <= 1'b1;
        else if (system_voltage_write &&
                 write_data[power_wakeup_pkg::SV_SOFT_FLAG_BIT])
            soft_flag_reg <= 1'b0;
    end

    a_soft_sets_flag: assert property (@(posedge clock) disable iff (reset)
        soft_trip |=> soft_flag_reg && system_reset)
        else $error("soft reset missed flag or reset");

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            osc_strong_mode <= power_wakeup_pkg::SV_OSC_STRONG_RESET;
            rtc_enable_reg <= power_wakeup_pkg::SV_RTC_EN_RESET;
        end
        else if (internal_reset)
        begin
            osc_strong_mode <= power_wakeup_pkg::SV_OSC_STRONG_RESET;
            rtc_enable_reg <= power_wakeup_pkg::SV_RTC_EN_RESET;
        end
        else if (system_voltage_write)
        begin
            osc_strong_mode <=
                write_data[power_wakeup_pkg::SV_OSC_STRONG_BIT];
            rtc_enable_reg <=
                write_data[power_wakeup_pkg::SV_RTC_EN_BIT];
        end
    end

    always_comb
    begin
        system_voltage_ctrl_reg = 16'h0000;
        system_voltage_ctrl_reg[power_wakeup_pkg::SV_OSC_STRONG_BIT] =
            osc_strong_mode;
        system_voltage_ctrl_reg[power_wakeup_pkg::SV_RTC_EN_BIT] =
            rtc_enable_reg;
        system_voltage_ctrl_reg[power_wakeup_pkg::SV_SOFT_FLAG_BIT] =
            soft_flag_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // low-voltage detect

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            lvd_level <= power_wakeup_pkg::VD_LEVEL_RESET;
        else if (internal_reset)
            lvd_level <= power_wakeup_pkg::VD_LEVEL_RESET;
        else if (voltage_detect_write)
            lvd_level <= write_data[power_wakeup_pkg::VD_LEVEL_LSB +: 2];
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            lvd_low_reg <= 1'b0;
        else
            lvd_low_reg <= lvd_below;
    end

    always_comb
    begin
        voltage_detect_ctrl_reg = 16'h0000;
        voltage_detect_ctrl_reg[power_wakeup_pkg::VD_LEVEL_LSB +: 2] =
            lvd_level;
        voltage_detect_ctrl_reg[power_wakeup_pkg::VD_LOW_BIT] =
            lvd_low_reg;
    end

    a_lvd_status: assert property (@(posedge clock) disable iff (reset)
        lvd_below |=> voltage_detect_ctrl_reg[12])
        else $error("low-voltage status bit not set");

    ////////////////////////////////////////////////////////////////////////
    // rtc: counts oscillator rising edges, half-second event

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            rtc_osc_prev_reg <= 1'b0;
        else
            rtc_osc_prev_reg <= rtc_osc;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rtc_count_reg <= 15'h0000;
            rtc_event <= 1'b0;
        end
        else if (!rtc_enable_reg)
        begin
            rtc_count_reg <= 15'h0000;
            rtc_event <= 1'b0;
        end
        else if (rtc_osc && !rtc_osc_prev_reg)
        begin
            rtc_event <= (rtc_count_reg == RTC_LAST);
            if (rtc_count_reg == RTC_LAST)
                rtc_count_reg <= 15'h0000;
            else
                rtc_count_reg <= rtc_count_reg + 15'h0001;
        end
        else
            rtc_event <= 1'b0;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            rtc_tick_count <= 16'h0000;
        else if (internal_reset)
            rtc_tick_count <= 16'h0000;
        else if (rtc_event)
            rtc_tick_count <= rtc_tick_count + 16'h0001;
    end

    a_rtc_off_quiet: assert property (@(posedge clock) disable iff (reset)
        !rtc_enable_reg |=> !rtc_event)
        else $error("rtc event while rtc disabled");

    ////////////////////////////////////////////////////////////////////////
    // key latch and wake sources

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            port_a_data_reg <= 16'h0000;
            key_latch_reg <= 8'h00;
        end
        else if (port_a_read)
        begin
            port_a_data_reg <= port_a_pins;
            key_latch_reg <= port_a_pins[power_wakeup_pkg::KEY_MSB:
                                         power_wakeup_pkg::KEY_LSB];
        end
    end

    assign key_change = key_wake_enable && (port_a_pins[
        power_wakeup_pkg::KEY_MSB:power_wakeup_pkg::KEY_LSB] !=
        key_latch_reg);
    assign irq_wake = |(irq_request & irq_enable);
    assign wake = key_change || rtc_event || irq_wake;

    ////////////////////////////////////////////////////////////////////////
    // power state

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            power_wakeup_pkg::ST_RUN:
            begin
                if (standby_entry_write &&
                    (write_data == power_wakeup_pkg::MAGIC_VALUE))
                    state_next = power_wakeup_pkg::ST_STANDBY;
                else if (halt_request)
                    state_next = power_wakeup_pkg::ST_HALT;
            end
            power_wakeup_pkg::ST_HALT,
            power_wakeup_pkg::ST_STANDBY:
            begin
                if (wake)
                    state_next = power_wakeup_pkg::ST_RUN;
            end
            default:
                state_next = power_wakeup_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            state_reg <= power_wakeup_pkg::ST_RUN;
        else if (internal_reset)
            state_reg <= power_wakeup_pkg::ST_RUN;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            wakeup_pulse <= 1'b0;
        else
            wakeup_pulse <= !internal_reset && wake &&
                (state_reg != power_wakeup_pkg::ST_RUN);
    end

    assign cpu_clock_enable = (state_reg == power_wakeup_pkg::ST_RUN);
    assign system_clock_enable =
        (state_reg != power_wakeup_pkg::ST_STANDBY);
    assign retention_hold =
        (state_reg == power_wakeup_pkg::ST_STANDBY);

    a_standby_entry: assert property (@(posedge clock) disable iff (reset)
        state_reg == power_wakeup_pkg::ST_RUN && !internal_reset &&
        standby_entry_write &&
        write_data == power_wakeup_pkg::MAGIC_VALUE |=>
        !cpu_clock_enable && !system_clock_enable)
        else $error("magic write did not enter standby");

    a_standby_holds: assert property (@(posedge clock) disable iff (reset)
        retention_hold && !wake && !internal_reset |=>
        retention_hold)
        else $error("standby left without a wake event");

    a_wake_resumes: assert property (@(posedge clock) disable iff (reset)
        retention_hold && wake && !internal_reset |=>
        cpu_clock_enable && system_clock_enable && wakeup_pulse &&
        !system_reset)
        else $error("wake did not restart clocks");

    a_halt_gating: assert property (@(posedge clock) disable iff (reset)
        state_reg == power_wakeup_pkg::ST_HALT |->
        !cpu_clock_enable && system_clock_enable)
        else $error("halt gated the wrong clocks");

    a_stack_reset: assert property (@(posedge clock) disable iff (reset)
        stack_trip |=> system_reset ##1 system_reset)
        else $error("stack violation did not reset");

endmodule

// ==== core/power_wakeup_pkg.sv ====
package power_wakeup_pkg;

    // magic value for standby entry and software reset
    localparam logic [15:0] MAGIC_VALUE = 16'h5555;

    // clock
    localparam int CLOCK_HZ = 40_000_000;

    // rtc: 32768 Hz oscillator, event every 0.5 s
    localparam int RTC_OSC_HZ = 32768;
    localparam int RTC_PERIOD_MS = 500;
    localparam int RTC_EDGES = RTC_OSC_HZ * RTC_PERIOD_MS / 1000;
    localparam int RTC_CNT_W = 15;

    // low-voltage reset: supply below 2.4 V for 4 consecutive cycles
    localparam logic [2:0] LVR_CYCLES = 3'h4;

    // watchdog period
    localparam int WDOG_PERIOD_MS = 750;
    localparam longint WDOG_CYCLES_L =
        longint'(CLOCK_HZ) * WDOG_PERIOD_MS / 1000;
    localparam int WDOG_CYCLES = int'(WDOG_CYCLES_L);

    // voltage-detect control register layout
    localparam int VD_LEVEL_LSB = 0;
    localparam int VD_LOW_BIT = 12;
    localparam logic [1:0] VD_LEVEL_RESET = 2'h0;
    // level codes: 0 = 2.6 V, 1 = 2.8 V, 2 = 3.0 V, 3 = 3.2 V
    localparam logic [1:0] VD_LEVEL_2V6 = 2'h0;
    localparam logic [1:0] VD_LEVEL_2V8 = 2'h1;
    localparam logic [1:0] VD_LEVEL_3V0 = 2'h2;
    localparam logic [1:0] VD_LEVEL_3V2 = 2'h3;

    // system voltage control register layout
    localparam int SV_OSC_STRONG_BIT = 0;
    localparam int SV_RTC_EN_BIT = 1;
    localparam int SV_SOFT_FLAG_BIT = 15;
    localparam logic SV_OSC_STRONG_RESET = 1'b1;
    localparam logic SV_RTC_EN_RESET = 1'b0;

    // key wakeup port bits
    localparam int KEY_MSB = 15;
    localparam int KEY_LSB = 8;

    // power states
    typedef enum logic [1:0]
    {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_STANDBY = 2'b10
    } power_state_t;

endpackage

// ==== test/cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model
#(
    parameter int ADDR_W = 16
)
(
    // clock
    input wire logic clock,
    // register strobes
    output logic standby_entry_write,
    output logic soft_reset_write,
    output logic voltage_detect_write,
    output logic system_voltage_write,
    output logic [15:0] write_data,
    output logic halt_request,
    // port, watchdog and stack
    output logic port_a_read,
    output logic watchdog_clear,
    output logic stack_access,
    output logic [ADDR_W-1:0] stack_addr
);
    bit kick_on = 1'b0;
    int kick_cnt = 0;
    initial
    begin
        {standby_entry_write, soft_reset_write} = 2'h0;
        {voltage_detect_write, system_voltage_write} = 2'h0;
        {halt_request, port_a_read, stack_access} = 3'h0;
        write_data = 16'h0000;
        stack_addr = '0;
        watchdog_clear = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // kind 0 standby, 1 soft reset, 2 voltage detect, 3 system voltage
    task automatic wr(input int kind, input logic [15:0] data);
        @(negedge clock);
        write_data = data;
        standby_entry_write = (kind == 0);
        soft_reset_write = (kind == 1);
        voltage_detect_write = (kind == 2);
        system_voltage_write = (kind == 3);
        @(negedge clock);
        {standby_entry_write, soft_reset_write} = 2'h0;
        {voltage_detect_write, system_voltage_write} = 2'h0;
        write_data = ~data;
    endtask
    // latch key state before sleeping
    task automatic read_port();
        @(negedge clock);
        port_a_read = 1'b1;
        @(negedge clock);
        port_a_read = 1'b0;
    endtask
    task automatic halt();
        @(negedge clock);
        halt_request = 1'b1;
        @(negedge clock);
        halt_request = 1'b0;
    endtask
    task automatic push(input logic [ADDR_W-1:0] addr);
        @(negedge clock);
        stack_addr = addr;
        stack_access = 1'b1;
        @(negedge clock);
        stack_access = 1'b0;
        stack_addr = ~addr;
    endtask
    ////////////////////////////////////////////////////////////////////
    // software keeps the watchdog fed well inside its period
    always @(negedge clock)
    begin
        kick_cnt <= (kick_cnt == 19) ? 0 : kick_cnt + 1;
        watchdog_clear <= kick_on && (kick_cnt == 0);
    end
endmodule

// ==== test/power_wakeup_reset_control_bench.sv ====
`timescale 1ns/1ps
module power_wakeup_reset_control_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic ext_reset_n = 1'b1;
    logic [15:0] port_a_pins = 16'h0000;
    logic key_wake_enable = 1'b0;
    logic [7:1] irq_request = 7'h00;
    logic [7:1] irq_enable = 7'h00;
    logic rtc_osc = 1'b0;
    logic lvd_below = 1'b0;
    logic supply_below_2v4 = 1'b0;
    logic watchdog_mask_option = 1'b0;
    logic [15:0] stack_top = 16'h0700;
    logic [15:0] stack_bottom = 16'h0600;
    logic sew, srw, vdw, svw, hreq, prd, wclr, sacc;
    logic [15:0] wdata, saddr, port_reg, rtc_cnt, vd_reg, sv_reg;
    logic osc_strong, rtc_ev, cpu_en, sys_en, hold, wake, system_reset;
    logic [1:0] lvd_level;
    int failures = 0;
    int n_tests = 0;
    int n_rtc_ev = 0;
    localparam logic [15:0] MAGIC = power_wakeup_pkg::MAGIC_VALUE;
    always #12.5 clock = ~clock;
    // one-cycle event pulses are counted mid-cycle
    always @(negedge clock)
        if (rtc_ev === 1'b1)
            n_rtc_ev++;
    cpu_model #(.ADDR_W(16)) cpu (.clock(clock),
        .standby_entry_write(sew), .soft_reset_write(srw),
        .voltage_detect_write(vdw), .system_voltage_write(svw),
        .write_data(wdata), .halt_request(hreq), .port_a_read(prd),
        .watchdog_clear(wclr), .stack_access(sacc), .stack_addr(saddr));
    power_wakeup_reset_control #(.WDOG_CYCLES(50), .RTC_EDGES(4),
        .ADDR_W(16)) DUT (.clock(clock), .reset(reset),
        .ext_reset_n(ext_reset_n), .standby_entry_write(sew),
        .soft_reset_write(srw), .voltage_detect_write(vdw),
        .system_voltage_write(svw), .write_data(wdata),
        .halt_request(hreq), .port_a_pins(port_a_pins),
        .port_a_read(prd), .key_wake_enable(key_wake_enable),
        .port_a_data_reg(port_reg), .irq_request(irq_request),
        .irq_enable(irq_enable), .rtc_osc(rtc_osc),
        .osc_strong_mode(osc_strong), .rtc_event(rtc_ev),
        .rtc_tick_count(rtc_cnt), .lvd_below(lvd_below),
        .supply_below_2v4(supply_below_2v4), .lvd_level(lvd_level),
        .voltage_detect_ctrl_reg(vd_reg), .system_voltage_ctrl_reg(sv_reg),
        .watchdog_mask_option(watchdog_mask_option),
        .watchdog_clear(wclr), .stack_access(sacc), .stack_addr(saddr),
        .stack_top(stack_top), .stack_bottom(stack_bottom),
        .cpu_clock_enable(cpu_en), .system_clock_enable(sys_en),
        .retention_hold(hold), .wakeup_pulse(wake),
        .system_reset(system_reset));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %0t %s seen %h want %h", $time, what, seen,
                exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wait_reset(input int n);
        for (int i = 0; i < n && system_reset !== 1'b1; i++) cyc(1);
    endtask
    task automatic settle();
        for (int i = 0; i < 20 && system_reset !== 1'b0; i++) cyc(1);
        cyc(2);
    endtask
    task automatic osc(input int n);
        repeat (n)
        begin
            rtc_osc = 1'b1;
            cyc(2);
            rtc_osc = 1'b0;
            cyc(2);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_standby_irq();
        for (int i = 1; i <= 7; i++)
        begin
            cpu.wr(0, 16'h5554);
            check(16'(cpu_en), 16'h1, "bad data slept");
            cpu.wr(0, MAGIC);
            check(16'({cpu_en, sys_en, hold}), 16'h1, "sleep");
            irq_request[i] = 1'b1;
            cyc(2);
            check(16'(hold), 16'h1, "masked irq woke");
            irq_enable[i] = 1'b1;
            cyc(1);
            check(16'({cpu_en, hold, wake}), 16'h5, "irq wake");
            check(16'(system_reset), 16'h0, "wake reset");
            {irq_request, irq_enable} = 14'h0000;
            cyc(1);
        end
    endtask
    task automatic t_key();
        port_a_pins = 16'hA5C3;
        cpu.read_port();
        check(port_reg, 16'hA5C3, "port latch");
        key_wake_enable = 1'b1;
        cpu.wr(0, MAGIC);
        port_a_pins = 16'hA5CB;
        cyc(3);
        check(16'(hold), 16'h1, "low bits woke");
        check(port_reg, 16'hA5C3, "port held");
        port_a_pins = 16'hB5CB;
        for (int i = 0; i < 4 && cpu_en !== 1'b1; i++) cyc(1);
        check(16'(cpu_en), 16'h1, "key wake");
        key_wake_enable = 1'b0;
    endtask
    task automatic t_rtc();
        osc(4);
        check(rtc_cnt, 16'h0000, "rtc off counted");
        cpu.wr(3, 16'h0002);
        check(16'(osc_strong), 16'h0, "weak mode");
        check(sv_reg, 16'h0002, "rtc enable");
        osc(4);
        check(rtc_cnt, 16'h0001, "rtc tick");
        cpu.wr(0, MAGIC);
        osc(4);
        check(16'(cpu_en), 16'h1, "rtc wake");
        check(rtc_cnt, 16'h0002, "standby tick");
        check(16'(n_rtc_ev), 16'h0002, "rtc events");
        cpu.wr(3, 16'h0001);
        check(16'(osc_strong), 16'h1, "strong mode");
    endtask
    task automatic t_halt();
        cpu.halt();
        check(16'({cpu_en, sys_en}), 16'h1, "halt");
        cpu.wr(0, MAGIC);
        check(16'(sys_en), 16'h1, "sleep in halt");
        {irq_request[3], irq_enable[3]} = 2'h3;
        cyc(1);
        check(16'(cpu_en), 16'h1, "halt wake");
        {irq_request, irq_enable} = 14'h0000;
    endtask
    task automatic t_lvd();
        for (int i = 0; i < 4; i++)
        begin
            cpu.wr(2, 16'(i));
            check(16'(lvd_level), 16'(i), "level");
            check(vd_reg & 16'h0003, 16'(i), "level field");
        end
        lvd_below = 1'b1;
        cyc(2);
        check(vd_reg & 16'h1000, 16'h1000, "low flag");
        lvd_below = 1'b0;
        cyc(2);
        check(vd_reg & 16'h1000, 16'h0000, "low flag clear");
    endtask
    task automatic t_lvr();
        supply_below_2v4 = 1'b1;
        cyc(3);
        supply_below_2v4 = 1'b0;
        cyc(3);
        check(16'(system_reset), 16'h0, "lvr short");
        supply_below_2v4 = 1'b1;
        wait_reset(8);
        check(16'(system_reset), 16'h1, "lvr");
        supply_below_2v4 = 1'b0;
        settle();
        check(16'(lvd_level), 16'h0, "lvr init");
    endtask
    task automatic t_soft();
        cpu.wr(1, 16'h5556);
        check(16'(system_reset), 16'h0, "bad soft");
        cpu.wr(1, MAGIC);
        check(16'(system_reset), 16'h1, "soft reset");
        settle();
        check(sv_reg, 16'h8001, "soft flag");
        cpu.wr(3, 16'h8001);
        check(sv_reg, 16'h0001, "flag clear");
    endtask
    task automatic t_stack();
        logic [15:0] addr [4] = '{16'h0600, 16'h0700, 16'h05FF, 16'h0701};
        for (int i = 0; i < 4; i++)
        begin
            cpu.push(addr[i]);
            check(16'(system_reset), 16'(i >= 2), "stack");
            settle();
        end
    endtask
    task automatic t_pin_wdog();
        ext_reset_n = 1'b0;
        cyc(1);
        check(16'(system_reset), 16'h1, "pin reset");
        ext_reset_n = 1'b1;
        settle();
        cyc(70);
        check(16'(system_reset), 16'h0, "wdog masked");
        watchdog_mask_option = 1'b1;
        reset = 1'b1;
        cyc(2);
        reset = 1'b0;
        cyc(3);
        cpu.kick_on = 1'b1;
        cyc(150);
        check(16'(system_reset), 16'h0, "wdog fed");
        cpu.kick_on = 1'b0;
        wait_reset(80);
        check(16'(system_reset), 16'h1, "wdog reset");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(4);
        check(16'(system_reset), 16'h1, "por");
        reset = 1'b0;
        cyc(3);
        check(16'(system_reset), 16'h0, "por release");
        check(sv_reg, 16'h0001, "sv reset");
        t_standby_irq();
        t_key();
        t_rtc();
        t_halt();
        t_lvd();
        t_lvr();
        t_soft();
        t_stack();
        t_pin_wdog();
        report_and_stop();
    end
    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
